// [inc/ltcfs_consts.svh]
// constants of the time-constant filter stage: key timing, ranges, widths
// assumes a 200 MHz clock and a time constant code counted in 1-3 steps, two codes per decade
`ifndef LTCFS_CONSTS_SVH
`define LTCFS_CONSTS_SVH
`define LTCFS_CLK_MHZ 200
`define LTCFS_LONG_PRESS_MS 1000
`define LTCFS_LONG_PRESS_CYC (`LTCFS_LONG_PRESS_MS * 1000 * `LTCFS_CLK_MHZ)
`define LTCFS_DW 24
`define LTCFS_TC_W 5
// time constant code: tc = 1us * {1,3} * 10^n; code 2n = 1x, 2n+1 = 3x
`define LTCFS_TC_3S 5'h0D
`define LTCFS_TC_10S 5'h0E
`define LTCFS_TC_30KS 5'h15
// rc pole coefficient shift per code: alpha = 2^-shift
`define LTCFS_SHIFT_BASE 4'h1
// gaussian fir: 5-tap binomial kernel 1 4 6 4 1, sum 16
`define LTCFS_FIR_NORM 4
`define LTCFS_POLES_W 2
`define LTCFS_POLES_RST 2'h0
`endif

// [inc/ltcfs_pkg.sv]
// types of the time-constant filter stage
// assumes the constants header is included by users beside this package
package ltcfs_pkg;
    typedef enum logic [1:0] {
        LTCFS_RC = 2'b00,
        LTCFS_GAUSS = 2'b01,
        LTCFS_LINPH = 2'b10
    } ltcfs_kind_e;
    typedef struct packed {
        logic signed [23:0] x;
        logic signed [23:0] y;
    } ltcfs_pair_s;
    typedef enum logic [1:0] {
        LTCFS_IDLE = 2'b00,
        LTCFS_HELD = 2'b01,
        LTCFS_LONG = 2'b10
    } ltcfs_key_e;
endpackage : ltcfs_pkg

// [design/ltcfs_stage.sv]
// one filter pole: rc, gaussian fir or linear-phase section on an x/y pair
// assumes samples arrive with a one-cycle strobe and clock enable from the parent
`timescale 1ns/100ps
`include "ltcfs_consts.svh"
module ltcfs_stage
    import ltcfs_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic stb,
    input wire ltcfs_kind_e kind,
    input wire logic [3:0] shift,
    input wire ltcfs_pair_s din,
    output ltcfs_pair_s dout
);
    ltcfs_pair_s acc_reg, acc_next;
    ltcfs_pair_s tap_reg [4], tap_next [4];
    ltcfs_pair_s sm_reg, sm_next;

    function automatic logic signed [23:0] rc_step(input logic signed [23:0] a,
            input logic signed [23:0] d, input logic [3:0] s);
        logic signed [24:0] diff;
        // one bit of headroom keeps a full-scale step from wrapping
        diff = 25'(d) - 25'(a);
        rc_step = a + 24'(diff >>> s);
    endfunction : rc_step

    function automatic logic signed [23:0] fir5(input logic signed [23:0] d,
            input logic signed [23:0] t0, input logic signed [23:0] t1,
            input logic signed [23:0] t2, input logic signed [23:0] t3);
        logic signed [27:0] s;
        s = 28'(d) + 28'(t3) + (28'(t0) <<< 2) + (28'(t2) <<< 2) + 28'(t1) * 28'sh6;
        fir5 = 24'(s >>> `LTCFS_FIR_NORM);
    endfunction : fir5

    always_comb begin
        acc_next = acc_reg;
        sm_next = sm_reg;
        for (int i = 0; i < 4; i++) tap_next[i] = tap_reg[i];
        if (stb) begin
            case (kind)
                LTCFS_GAUSS: begin
                    // binomial kernel approximates a gaussian of equal noise bandwidth
                    acc_next.x = fir5(din.x, tap_reg[0].x, tap_reg[1].x,
                        tap_reg[2].x, tap_reg[3].x);
                    acc_next.y = fir5(din.y, tap_reg[0].y, tap_reg[1].y,
                        tap_reg[2].y, tap_reg[3].y);
                    tap_next[0] = din;
                    for (int i = 1; i < 4; i++) tap_next[i] = tap_reg[i-1];
                end
                LTCFS_LINPH: begin
                    // forward rc then smoothing pass keeps rc stop band slope
                    acc_next.x = rc_step(acc_reg.x, din.x, shift);
                    acc_next.y = rc_step(acc_reg.y, din.y, shift);
                    sm_next.x = rc_step(sm_reg.x, acc_reg.x, shift + 4'h1);
                    sm_next.y = rc_step(sm_reg.y, acc_reg.y, shift + 4'h1);
                end
                default: begin
                    acc_next.x = rc_step(acc_reg.x, din.x, shift);
                    acc_next.y = rc_step(acc_reg.y, din.y, shift);
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_reg <= '0;
            sm_reg <= '0;
            for (int i = 0; i < 4; i++) tap_reg[i] <= '0;
        end else if (ce) begin
            acc_reg <= acc_next;
            sm_reg <= sm_next;
            for (int i = 0; i < 4; i++) tap_reg[i] <= tap_next[i];
        end
    end

    assign dout = (kind == LTCFS_LINPH) ? sm_reg : acc_reg;
endmodule : ltcfs_stage

// [design/ltcfs_top.sv]
// time-constant filter stage with rc or advanced filtering and a fast feedback path
// assumes mixer samples with a strobe and a debounced, synchronous slope key level
`timescale 1ns/100ps
`include "ltcfs_consts.svh"
module ltcfs_top
    import ltcfs_pkg::*;
#(
    parameter int unsigned LONG_PRESS_CYC = `LTCFS_LONG_PRESS_CYC
)(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic slope_key,
    input wire logic [4:0] tc_code,
    input wire logic mix_valid,
    input wire ltcfs_pair_s mix_data,
    output ltcfs_pair_s main_out,
    output logic main_valid,
    output ltcfs_pair_s fast_feedback_output,
    output logic advanced_led,
    output logic [1:0] poles_out,
    output ltcfs_kind_e kind_out
);
    ltcfs_key_e key_reg, key_next;
    logic [31:0] hold_reg, hold_next;
    logic adv_reg, adv_next;
    logic [1:0] poles_reg, poles_next;
    ltcfs_kind_e kind_reg, kind_next;
    ltcfs_pair_s main_reg, main_next, fb_reg, fb_next;
    logic vld_reg, vld_next, stb_d_reg;
    logic [3:0] shift;
    ltcfs_pair_s adv_chain [5];
    ltcfs_pair_s rc_chain [5];

    function automatic ltcfs_kind_e pick_kind(input logic adv, input logic [4:0] tc);
        if (!adv) pick_kind = LTCFS_RC;
        else if (tc <= `LTCFS_TC_3S) pick_kind = LTCFS_GAUSS;
        else if (tc >= `LTCFS_TC_10S && tc <= `LTCFS_TC_30KS) pick_kind = LTCFS_LINPH;
        else pick_kind = LTCFS_RC;
    endfunction : pick_kind

    assign shift = 4'(tc_code[4:1]) + `LTCFS_SHIFT_BASE;

    // key: short release steps poles, hold past threshold toggles advanced
    always_comb begin
        key_next = key_reg;
        hold_next = hold_reg;
        adv_next = adv_reg;
        poles_next = poles_reg;
        case (key_reg)
            LTCFS_IDLE: begin
                hold_next = '0;
                if (slope_key) key_next = LTCFS_HELD;
            end
            LTCFS_HELD: begin
                if (!slope_key) begin
                    poles_next = poles_reg + 2'h1;
                    key_next = LTCFS_IDLE;
                end else if (hold_reg >= LONG_PRESS_CYC - 1) begin
                    adv_next = !adv_reg;
                    key_next = LTCFS_LONG;
                end else begin
                    hold_next = hold_reg + 32'h1;
                end
            end
            LTCFS_LONG: begin
                if (!slope_key) key_next = LTCFS_IDLE;
            end
            default: key_next = LTCFS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            key_reg <= LTCFS_IDLE;
            hold_reg <= '0;
            adv_reg <= 1'b0;
            poles_reg <= `LTCFS_POLES_RST;
        end else if (ce) begin
            key_reg <= key_next;
            hold_reg <= hold_next;
            adv_reg <= adv_next;
            poles_reg <= poles_next;
        end
    end

    // mode register and output selection
    always_comb begin
        kind_next = pick_kind(adv_reg, tc_code);
        // single linear-phase pole is the rc pole itself
        if (kind_next == LTCFS_LINPH && poles_reg == 2'h0) kind_next = LTCFS_RC;
        main_next = main_reg;
        fb_next = fb_reg;
        vld_next = 1'b0;
        if (stb_d_reg) begin
            main_next = adv_chain[poles_reg + 3'h1];
            fb_next = rc_chain[poles_reg + 3'h1];
            vld_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            kind_reg <= LTCFS_RC;
            main_reg <= '0;
            fb_reg <= '0;
            vld_reg <= 1'b0;
            stb_d_reg <= 1'b0;
        end else if (ce) begin
            kind_reg <= kind_next;
            main_reg <= main_next;
            fb_reg <= fb_next;
            vld_reg <= vld_next;
            stb_d_reg <= mix_valid;
        end
    end

    assign adv_chain[0] = mix_data;
    assign rc_chain[0] = mix_data;

    // identical cascaded stages; the feedback chain is forced to rc
    generate
        for (genvar g = 0; g < 4; g++) begin : g_pole
            ltcfs_stage u_adv (
                .clk(clk),
                .sys_rst(sys_rst),
                .ce(ce),
                .stb(mix_valid),
                .kind(kind_reg),
                .shift(shift),
                .din(adv_chain[g]),
                .dout(adv_chain[g+1])
            );
            ltcfs_stage u_rc (
                .clk(clk),
                .sys_rst(sys_rst),
                .ce(ce),
                .stb(mix_valid),
                .kind(LTCFS_RC),
                .shift(shift),
                .din(rc_chain[g]),
                .dout(rc_chain[g+1])
            );
        end
    endgenerate

    always_comb begin
        main_out = main_reg;
        main_valid = vld_reg;
        fast_feedback_output = fb_reg;
        advanced_led = adv_reg;
        poles_out = poles_reg;
        kind_out = kind_reg;
    end
endmodule : ltcfs_top

// [tb/ltcfs_monitor.sv]
// checker for the time-constant filter stage, bound to its top module
// assumes the key counter advances only on edges with ce high, as the design does
`timescale 1ns/100ps
module ltcfs_monitor
    import ltcfs_pkg::*;
#(
    parameter int unsigned LONG_PRESS_CYC = 20
)(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic slope_key,
    input wire logic [4:0] tc_code,
    input wire logic advanced_led,
    input wire logic [1:0] poles_out,
    input wire ltcfs_kind_e kind_out
);
    logic [31:0] hold_reg, hold_next;
    logic key_reg, led_reg, led_next;
    logic [1:0] pol_reg, pol_next;
    // settings seen when the key went down
    always_comb begin
        hold_next = slope_key ? hold_reg + 32'h1 : 32'h0;
        led_next = (slope_key && !key_reg) ? advanced_led : led_reg;
        pol_next = (slope_key && !key_reg) ? poles_out : pol_reg;
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hold_reg <= 32'h0;
            key_reg <= 1'b0;
        end else if (ce) begin
            hold_reg <= hold_next;
            key_reg <= slope_key;
            led_reg <= led_next;
            pol_reg <= pol_next;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst || !ce);
    // hold_reg counts enabled edges with the key down; the toggle edge is the one
    // that sees the key down for the LONG_PRESS_CYC+1-th time
    sequence s_short_release;
        $fell(slope_key) && hold_reg <= LONG_PRESS_CYC;
    endsequence
    sequence s_long_reached;
        slope_key && hold_reg == LONG_PRESS_CYC;
    endsequence
    a_short_step:
        assert property (s_short_release |-> ##1 poles_out == pol_reg + 2'h1) else $error("no step");
    a_long_toggle:
        assert property (s_long_reached |-> ##1 advanced_led != led_reg) else $error("no toggle");
    a_led_cause:
        assert property ($changed(advanced_led) |-> $past(slope_key)) else $error("led moved");
    a_gauss_range:
        assert property (kind_out == LTCFS_GAUSS |-> $past(advanced_led) && $past(tc_code) <= 5'h0D)
        else $error("fir out of range");
    a_gauss_use:
        assert property ($past(advanced_led) && $past(tc_code) <= 5'h0D |-> kind_out == LTCFS_GAUSS)
        else $error("fir not used");
    a_linph_range:
        assert property (kind_out == LTCFS_LINPH |-> $past(advanced_led) && $past(poles_out) != 2'h0
            && $past(tc_code) inside {[5'h0E:5'h15]}) else $error("linear phase misused");
    a_linph_use:
        assert property ($past(advanced_led) && $past(poles_out) != 2'h0 && $past(tc_code) >= 5'h0E
            && $past(tc_code) <= 5'h15 |-> kind_out == LTCFS_LINPH) else $error("no linear phase");
    a_rc_fallback:
        assert property (!$past(advanced_led) || $past(tc_code) > 5'h15 |-> kind_out == LTCFS_RC)
        else $error("rc not used");
endmodule : ltcfs_monitor
bind ltcfs_top ltcfs_monitor #(.LONG_PRESS_CYC(LONG_PRESS_CYC)) i_ltcfs_monitor (.clk(clk),
    .sys_rst(sys_rst), .ce(ce), .slope_key(slope_key), .tc_code(tc_code),
    .advanced_led(advanced_led),
    .poles_out(poles_out), .kind_out(kind_out));

// [tb/ltcfs_mixer_model.sv]
// mixer model: sends one sample with a one-cycle strobe when asked
// assumes the bench raises send just after a falling edge
`timescale 1ns/100ps
module ltcfs_mixer_model
    import ltcfs_pkg::*;
(
    input wire logic clk,
    input wire logic send,
    input wire ltcfs_pair_s val,
    output logic mix_valid,
    output ltcfs_pair_s mix_data
);
    initial mix_valid = 1'b0;
    initial mix_data = '0;
    // data is not held between strobes, so flip it each cycle
    always @(negedge clk) begin
        mix_valid = send;
        mix_data = send ? val : ~mix_data;
    end
endmodule : ltcfs_mixer_model

// [tb/testbench.sv]
// self-checking bench for the time-constant filter stage
// assumes the mixer model and a short long-press count
`timescale 1ns/100ps
module testbench;
    import ltcfs_pkg::*;
    localparam int LP = 20;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    logic key = 1'b0;
    logic [4:0] tc = 5'h00;
    logic send = 1'b0;
    ltcfs_pair_s val = '0;
    logic mv, ov, led;
    ltcfs_pair_s md, mo, fo;
    logic [1:0] poles;
    ltcfs_kind_e kind;
    int num_errors = 0;
    int n_compared = 0;
    always #2.5 clk = ~clk;
    ltcfs_mixer_model i_ltcfs_mixer_model (.clk(clk), .send(send), .val(val), .mix_valid(mv),
        .mix_data(md));
    ltcfs_top #(.LONG_PRESS_CYC(LP)) i_ltcfs_top (.clk(clk), .sys_rst(sys_rst), .ce(ce),
        .slope_key(key), .tc_code(tc), .mix_valid(mv), .mix_data(md), .main_out(mo),
        .main_valid(ov), .fast_feedback_output(fo), .advanced_led(led), .poles_out(poles),
        .kind_out(kind));
    task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic do_reset;
        sys_rst <= 1'b1;
        tc <= 5'h00;
        repeat (2) @(negedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
    endtask : do_reset
    task automatic press(input int n);
        key <= 1'b1;
        repeat (n) @(negedge clk);
        key <= 1'b0;
        repeat (3) @(negedge clk);
    endtask : press
    task automatic set_tc(input logic [4:0] c);
        tc <= c;
        repeat (3) @(negedge clk);
    endtask : set_tc
    task automatic t_reset;
        do_reset;
        chk("main_out", mo, 48'h0);
        chk("fast out", fo, 48'h0);
        chk("state", {42'h0, ov, led, poles, kind}, 48'h0);
    endtask : t_reset
    task automatic t_poles;
        for (int i = 1; i <= 4; i++) begin
            press(2);
            chk("poles", {46'h0, poles}, 48'(i % 4));
        end
        // LP sampled edges is still short; LP+1 is the first long press
        press(LP);
        chk("edge short", {45'h0, led, poles}, 48'h1);
        press(LP + 1);
        chk("edge long on", {45'h0, led, poles}, 48'h5);
        press(LP + 1);
        chk("edge long off", {45'h0, led, poles}, 48'h1);
        chk("kind", {46'h0, kind}, 48'h0);
    endtask : t_poles
    task automatic t_freeze;
        ce <= 1'b0;
        @(negedge clk);
        press(2);
        chk("frozen poles", {46'h0, poles}, 48'h1);
        send <= 1'b1;
        @(negedge clk);
        send <= 1'b0;
        repeat (4) begin
            @(negedge clk);
            chk("frozen valid", {47'h0, ov}, 48'h0);
        end
        ce <= 1'b1;
        @(negedge clk);
    endtask : t_freeze
    task automatic t_modes;
        logic [4:0] codes [6] = '{5'h00, 5'h0D, 5'h0E, 5'h15, 5'h16, 5'h1F};
        ltcfs_kind_e kinds [6] = '{LTCFS_GAUSS, LTCFS_GAUSS, LTCFS_LINPH, LTCFS_LINPH,
            LTCFS_RC, LTCFS_RC};
        do_reset;
        press(LP + 4);
        chk("led on", {47'h0, led}, 48'h1);
        press(2);
        for (int i = 0; i < 6; i++) begin
            set_tc(codes[i]);
            chk("kind", {46'h0, kind}, {46'h0, kinds[i]});
        end
        set_tc(5'h0E);
        repeat (3) press(2);
        chk("one pole kind", {46'h0, kind}, 48'h0);
        press(LP + 4);
        chk("led off", {47'h0, led}, 48'h0);
        chk("poles kept", {46'h0, poles}, 48'h0);
    endtask : t_modes
    task automatic t_data(input logic [4:0] c, input logic [47:0] exp,
            input logic [47:0] exm);
        do_reset;
        press(LP + 4);
        set_tc(c);
        val <= {24'h100000, 24'hF00000};
        send <= 1'b1;
        @(negedge clk);
        send <= 1'b0;
        for (int i = 0; i < 8 && ov !== 1'b1; i++) @(negedge clk);
        chk("main_valid", {47'h0, ov}, 48'h1);
        chk("fast out", fo, exp);
        chk("main out", mo, exm);
        if (c == 5'h00)
            chk("kind", {46'h0, kind}, 48'h1);
        else
            chk("kind", {46'h0, kind}, 48'h0);
    endtask : t_data
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    initial begin
        t_reset;
        t_poles;
        t_freeze;
        t_modes;
        // first sample weight of the 1 4 6 4 1 kernel is 1/16
        t_data(5'h00, {24'h080000, 24'hF80000}, {24'h010000, 24'hFF0000});
        t_data(5'h0E, {24'h001000, 24'hFFF000}, {24'h001000, 24'hFFF000});
        t_data(5'h16, {24'h000100, 24'hFFFF00}, {24'h000100, 24'hFFFF00});
        final_report;
    end
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        final_report;
    end
endmodule : testbench
